// File: hdl/dram_fifo_controller.sv
`timescale 1ns/1ps
`default_nettype none
module dram_fifo_controller
   import fifo_ctl_pkg::*;
#(
   parameter int unsigned REFRESH_CYCLES = REFRESH_INTERVAL_CYCLES,
   parameter int unsigned ADDR_W = 8
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic read_request_n,
   input wire logic write_request_n,
   input wire logic refresh_request_clock,
   input wire logic internal_refresh_en,
   input wire logic addr_ready,
   output logic read_ready,
   output logic write_ready,
   output logic [ADDR_W-1:0] dram_addr,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic oe_n,
   output logic access_enable,
   output logic refresh_enable,
   output logic full,
   output logic half_full,
   output logic empty,
   output logic addr_valid,
   output logic [ADDR_W:0] addr_word
);
   localparam int CW = $clog2(REFRESH_CYCLES + 1);
   typedef struct packed {
      logic [1:0] rd_sync;
      logic [1:0] wr_sync;
      logic [1:0] rf_sync;
      logic rf_prev;
      logic rd_pend;
      logic wr_pend;
      logic rf_pend;
      logic [CW-1:0] rf_cnt;
      acc_state_t acc;
      ref_state_t rfs;
      logic is_write;
      logic hold;
      logic ras;
      logic rcs;
      logic cas;
      logic we;
      logic oe;
      logic acc_en;
      logic ref_en;
      logic rd_rdy;
      logic wr_rdy;
      logic [PTR_W-1:0] wptr;
      logic [PTR_W-1:0] rptr;
      logic [PTR_W-1:0] addr_latch;
      logic [ADDR_W-1:0] addr;
      logic [PTR_W-1:0] count;
      logic full;
      logic half;
      logic empty;
   } ctl_state_t;
   ctl_state_t s_q, s_d;
   addr_stream_if #(.W(ADDR_W + 1)) buf_in ();
   addr_stream_if #(.W(ADDR_W + 1)) buf_out ();
   skid_buffer #(.W(ADDR_W + 1), .DEPTH(BUF_DEPTH)) u_buf (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .in_s(buf_in),
      .out_s(buf_out)
   );
   logic rd_req, wr_req, rf_req, ras_next, tick;
   always_comb begin
      s_d = s_q;
      s_d.rd_sync = {s_q.rd_sync[0], ~read_request_n};
      s_d.wr_sync = {s_q.wr_sync[0], ~write_request_n};
      s_d.rf_sync = {s_q.rf_sync[0], ~refresh_request_clock};
      rd_req = s_q.rd_sync[1];
      wr_req = s_q.wr_sync[1];
      s_d.rf_prev = s_q.rf_sync[1];
      // Internal interval timer when no external request clock is fitted
      tick = 1'b0;
      if (internal_refresh_en) begin
         if (s_q.rf_cnt == CW'(REFRESH_CYCLES - 1)) begin
            s_d.rf_cnt = '0;
            tick = 1'b1;
         end else begin
            s_d.rf_cnt = s_q.rf_cnt + 1'b1;
         end
      end
      rf_req = (s_q.rf_sync[1] && !s_q.rf_prev) || tick;
      if (rf_req) begin
         s_d.rf_pend = 1'b1;
      end
      if (rd_req && s_q.rd_rdy) begin
         s_d.rd_pend = 1'b1;
         s_d.rd_rdy = 1'b0;
      end
      if (wr_req && s_q.wr_rdy) begin
         s_d.wr_pend = 1'b1;
         s_d.wr_rdy = 1'b0;
      end
      // Strobe state equation, evaluated in active-high terms
      ras_next = (!s_q.ras && s_q.rcs && !s_q.cas) || (s_q.ref_en && s_q.cas);
      buf_in.valid = 1'b0;
      buf_in.data = '0;
      unique case (s_q.acc)
         ST_IDLE: begin
            // Refresh first, then write, then read; only between cycles
            if (s_q.rfs == RF_IDLE && !s_q.rf_pend && buf_in.ready) begin
               if (s_q.wr_pend) begin
                  s_d.acc = ST_ROW;
                  s_d.is_write = 1'b1;
                  s_d.acc_en = 1'b1;
                  s_d.addr_latch = s_q.wptr;
                  s_d.wptr = s_q.wptr + 1'b1;
               end else if (s_q.rd_pend) begin
                  s_d.acc = ST_ROW;
                  s_d.is_write = 1'b0;
                  s_d.acc_en = 1'b1;
                  s_d.addr_latch = s_q.rptr;
                  s_d.rptr = s_q.rptr + 1'b1;
               end
               if (s_q.wr_pend || s_q.rd_pend) begin
                  // Count steps once per granted access
                  if (s_q.wr_pend) begin
                     s_d.count = s_q.count + 1'b1;
                  end else begin
                     s_d.count = s_q.count - 1'b1;
                  end
               end
            end
         end
         ST_ROW: begin
            s_d.rcs = 1'b1;
            s_d.addr = s_q.addr_latch[ROW_LSB +: ADDR_W];
            s_d.acc = ST_RAS;
         end
         ST_RAS: begin
            s_d.ras = ras_next;
            s_d.acc = ST_COL;
         end
         ST_COL: begin
            s_d.rcs = 1'b0;
            s_d.addr = s_q.addr_latch[COL_LSB +: ADDR_W];
            s_d.we = s_q.is_write;
            s_d.oe = !s_q.is_write;
            s_d.acc = ST_CAS;
         end
         ST_CAS: begin
            s_d.cas = 1'b1;
            s_d.acc = ST_HOLD;
         end
         ST_HOLD: begin
            // Two held cycles; the second ends the access, RAS and CAS drop together
            if (!s_q.hold) begin
               s_d.hold = 1'b1;
            end else begin
               s_d.hold = 1'b0;
               s_d.ras = 1'b0;
               s_d.cas = 1'b0;
               s_d.we = 1'b0;
               s_d.oe = 1'b0;
               s_d.rcs = 1'b1;
               s_d.acc_en = 1'b0;
               s_d.acc = ST_IDLE;
               buf_in.valid = 1'b1;
               buf_in.data = {s_q.is_write, s_q.addr};
               if (s_q.is_write) begin
                  s_d.wr_pend = 1'b0;
                  s_d.wr_rdy = !s_q.rf_pend;
               end else begin
                  s_d.rd_pend = 1'b0;
                  s_d.rd_rdy = !s_q.rf_pend;
               end
            end
         end
      endcase
      unique case (s_q.rfs)
         RF_IDLE: begin
            if (s_q.rf_pend && s_q.acc == ST_IDLE) begin
               s_d.rfs = RF_CAS;
               s_d.ref_en = 1'b1;
               s_d.rd_rdy = 1'b0;
               s_d.wr_rdy = 1'b0;
            end
         end
         RF_CAS: begin
            s_d.cas = 1'b1;
            s_d.rfs = RF_RAS;
         end
         RF_RAS: begin
            s_d.ras = ras_next;
            s_d.rfs = RF_END;
         end
         RF_END: begin
            s_d.ras = 1'b0;
            s_d.cas = 1'b0;
            s_d.ref_en = 1'b0;
            s_d.rf_pend = rf_req;
            s_d.rd_rdy = !s_q.rd_pend;
            s_d.wr_rdy = !s_q.wr_pend;
            s_d.rfs = RF_IDLE;
         end
      endcase
      // Half-full is a monitor only and feeds no grant
      s_d.empty = (s_d.count == COUNT_EMPTY);
      s_d.full = (s_d.count == COUNT_FULL);
      s_d.half = (s_d.count >= COUNT_HALF);
   end
   assign buf_out.ready = addr_ready;
   // Buffer output is already a register; a second stage would break the handshake
   assign addr_valid = buf_out.valid;
   assign addr_word = buf_out.data;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
         s_q.rcs <= 1'b1;
         s_q.rd_rdy <= 1'b1;
         s_q.wr_rdy <= 1'b1;
         s_q.empty <= 1'b1;
         s_q.wptr <= PTR_RESET;
         s_q.rptr <= PTR_RESET;
      end else begin
         s_q <= s_d;
      end
   end
   // Output stage: strobes registered, RAS forced inactive by set
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ras_n <= 1'b1;
         cas_n <= 1'b1;
         we_n <= 1'b1;
         oe_n <= 1'b1;
         read_ready <= 1'b1;
         write_ready <= 1'b1;
         dram_addr <= '0;
         access_enable <= 1'b0;
         refresh_enable <= 1'b0;
         full <= 1'b0;
         half_full <= 1'b0;
         empty <= 1'b1;
      end else begin
         ras_n <= !s_d.ras;
         cas_n <= !s_d.cas;
         we_n <= !s_d.we;
         // Output enable lags RAS by one clock on reads
         oe_n <= !s_d.oe;
         read_ready <= s_d.rd_rdy && !s_d.rd_pend;
         write_ready <= s_d.wr_rdy && !s_d.wr_pend;
         dram_addr <= s_d.addr;
         access_enable <= s_d.acc_en;
         refresh_enable <= s_d.ref_en;
         full <= s_d.full;
         half_full <= s_d.half;
         empty <= s_d.empty;
      end
   end
endmodule
`default_nettype wire

// File: shared/fifo_ctl_pkg.sv
// What this block does
// - Read ready held low during read cycle
// - Read mirrors write timing, write enable high, output enable delayed
// - Refresh request starts CAS-before-RAS, readies low
// - Refresh: CAS after first edge, RAS after second
// - Third refresh edge releases strobes and readies
// - Access and refresh enables never both true
// - Next RAS follows the state equation
// - 256 refreshes per 4 ms, 40 MHz clock
// - Separate 16-bit write and read pointers
// - Row select high gives row byte, low column
// - Read grant advances read pointer, same address sequence
// - Full, half-full, empty outputs active high
// - Half-full only reports, never gates access
// - Status counter steps on access enable
// - Count up on write, down on read
// - Empty at 0000, full FFFF, half 7FFF
// - RAS from registered stage with set
// - Priority refresh, then write, then read
// - Row, RAS, column, CAS, hold two cycles
// - Requests clear when done, idle strobes high
package fifo_ctl_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned REFRESH_ROWS = 256;
   localparam int unsigned REFRESH_PERIOD_US = 4000;
   localparam int unsigned REFRESH_INTERVAL_CYCLES =
      (CLK_HZ / 1000) * (REFRESH_PERIOD_US / 1000) / REFRESH_ROWS;
   localparam int unsigned PTR_W = 16;
   localparam logic [15:0] COUNT_EMPTY = 16'h0000;
   localparam logic [15:0] COUNT_FULL = 16'hFFFF;
   localparam logic [15:0] COUNT_HALF = 16'h7FFF;
   localparam logic [15:0] PTR_RESET = 16'h0000;
   localparam int unsigned ROW_LSB = 8;
   localparam int unsigned COL_LSB = 0;
   localparam int unsigned BUF_DEPTH = 2;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ROW, ST_RAS, ST_COL, ST_CAS, ST_HOLD
   } acc_state_t;
   typedef enum logic [1:0] {
      RF_IDLE, RF_CAS, RF_RAS, RF_END
   } ref_state_t;
endpackage

// File: shared/addr_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface addr_stream_if #(parameter int W = 17);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: hdl/skid_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module skid_buffer
   import fifo_ctl_pkg::*;
#(
   parameter int W = 17,
   parameter int DEPTH = BUF_DEPTH
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   addr_stream_if.snk in_s,
   addr_stream_if.src out_s
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
      logic [W-1:0] dout;
      logic dvalid;
   } buf_state_t;
   buf_state_t s_q, s_d;
   logic push, pop, load, room;
   // Output register counts as one of the entries, so a stall holds at most DEPTH words
   assign room = (s_q.cnt + (AW+1)'(s_q.dvalid)) != (AW+1)'(DEPTH);
   always_comb begin
      s_d = s_q;
      push = in_s.valid && room;
      load = !s_q.dvalid || out_s.ready;
      pop = load && (s_q.cnt != '0);
      if (load) begin
         s_d.dvalid = pop;
         if (pop) begin
            s_d.dout = s_q.mem[s_q.rd];
            s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
         end
      end
      if (push) begin
         s_d.mem[s_q.wr] = in_s.data;
         s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
      end
      s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign in_s.ready = room;
   assign out_s.valid = s_q.dvalid;
   assign out_s.data = s_q.dout;
endmodule
`default_nettype wire

// File: verification/fifo_ctl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module fifo_ctl_checker (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic read_ready,
   input wire logic write_ready,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic access_enable,
   input wire logic refresh_enable,
   input wire logic full,
   input wire logic half_full,
   input wire logic empty
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   a_enables_exclusive: assert property (!(access_enable && refresh_enable))
      else $error("access and refresh enables both high");
   a_refresh_cas_first: assert property (refresh_enable && $fell(cas_n) |-> ras_n ##1 $fell(ras_n))
      else $error("refresh strobe order wrong");
   a_refresh_release: assert property (refresh_enable && $fell(ras_n) |=> ras_n && cas_n)
      else $error("refresh strobes not released");
   a_refresh_readies: assert property (refresh_enable && !cas_n |-> !read_ready && !write_ready)
      else $error("ready high during refresh");
   a_read_we_high: assert property (!oe_n |-> we_n && !read_ready)
      else $error("read with write strobe or ready high");
   a_oe_after_ras: assert property ($fell(oe_n) |-> !$past(ras_n) && $past(ras_n, 2))
      else $error("output enable not one cycle after row strobe");
   a_cas_after_ras: assert property (!refresh_enable && $fell(ras_n) |-> ##2 $fell(cas_n))
      else $error("column strobe not two cycles after row strobe");
   a_access_hold: assert property (!refresh_enable && $fell(cas_n) |=> !ras_n && !cas_n ##1 ras_n && cas_n)
      else $error("access strobes not held two cycles");
   a_flags_sane: assert property (!(full && empty) && (!full || half_full))
      else $error("status flags inconsistent");
endmodule
`default_nettype wire

// File: verification/addr_sink.sv
`timescale 1ns/1ps
`default_nettype none
module addr_sink (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic stall,
   input wire logic addr_valid,
   input wire logic [8:0] addr_word,
   output logic addr_ready
);
   logic [8:0] got[$];
   logic slow_q;
   // Slow consumer: ready only every other cycle
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         slow_q <= 1'b0;
      end else begin
         slow_q <= ~slow_q;
         if (addr_valid && addr_ready) got.push_back(addr_word);
      end
   end
   assign addr_ready = ~stall & slow_q;
endmodule
`default_nettype wire

// File: verification/tb_dram_fifo_controller.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dram_fifo_controller;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic read_request_n = 1'b1;
   logic write_request_n = 1'b1;
   logic refresh_request_clock = 1'b1;
   logic internal_refresh_en = 1'b0;
   logic stall = 1'b0;
   logic addr_ready, read_ready, write_ready, ras_n, cas_n, we_n, oe_n;
   logic access_enable, refresh_enable, full, half_full, empty, addr_valid;
   logic [7:0] dram_addr;
   logic [8:0] addr_word;
   int err_total = 0;
   int tests_run = 0;
   always #12.5 sys_clk = ~sys_clk;
   dram_fifo_controller #(.REFRESH_CYCLES(20)) dram_fifo_controller_i (.sys_clk(sys_clk),
      .arst_n(arst_n), .read_request_n(read_request_n), .write_request_n(write_request_n),
      .refresh_request_clock(refresh_request_clock), .internal_refresh_en(internal_refresh_en),
      .addr_ready(addr_ready), .read_ready(read_ready), .write_ready(write_ready),
      .dram_addr(dram_addr), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n),
      .access_enable(access_enable), .refresh_enable(refresh_enable), .full(full),
      .half_full(half_full), .empty(empty), .addr_valid(addr_valid), .addr_word(addr_word));
   addr_sink addr_sink_i (.sys_clk(sys_clk), .arst_n(arst_n), .stall(stall),
      .addr_valid(addr_valid), .addr_word(addr_word), .addr_ready(addr_ready));
   task automatic end_sim;
      if (err_total == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_lvl(ref logic s, input logic v);
      int n;
      n = 0;
      while (s !== v && n < 400) begin
         @(posedge sys_clk);
         n++;
      end
      if (s !== v) chk(s, v);
   endtask
   task automatic acc(input logic rd);
      if (rd) read_request_n <= 1'b0;
      else write_request_n <= 1'b0;
      if (rd) wait_lvl(read_ready, 1'b0);
      else wait_lvl(write_ready, 1'b0);
      // Hold until granted, so a refresh cannot swallow it
      wait_lvl(access_enable, 1'b1);
      if (rd) read_request_n <= 1'b1;
      else write_request_n <= 1'b1;
      if (rd) wait_lvl(read_ready, 1'b1);
      else wait_lvl(write_ready, 1'b1);
   endtask
   task automatic s_fifo;
      int b;
      b = addr_sink_i.got.size();
      for (int i = 0; i < 3; i++) acc(1'b0);
      chk(empty, 1'b0);
      chk({full, half_full}, 2'b00);
      for (int i = 0; i < 3; i++) acc(1'b1);
      chk(empty, 1'b1);
      repeat (6) @(posedge sys_clk);
      chk(addr_sink_i.got.size(), b + 6);
      for (int i = 0; i < 3; i++) begin
         chk(addr_sink_i.got[b+i], {1'b1, fifo_ctl_pkg::PTR_RESET[7:0] + 8'(i)});
         chk(addr_sink_i.got[b+3+i], {1'b0, fifo_ctl_pkg::PTR_RESET[7:0] + 8'(i)});
      end
   endtask
   task automatic s_stall;
      int b;
      logic saw;
      b = addr_sink_i.got.size();
      saw = 1'b0;
      stall <= 1'b1;
      acc(1'b0);
      acc(1'b0);
      fork
         acc(1'b0);
         begin
            repeat (15) begin
               @(posedge sys_clk);
               if (ras_n === 1'b0) saw = 1'b1;
            end
            stall <= 1'b0;
         end
      join
      chk(saw, 1'b0);
      repeat (6) @(posedge sys_clk);
      chk(addr_sink_i.got.size(), b + 3);
   endtask
   task automatic s_priority;
      refresh_request_clock <= 1'b0;
      write_request_n <= 1'b0;
      wait_lvl(refresh_enable, 1'b1);
      chk(access_enable, 1'b0);
      wait_lvl(cas_n, 1'b0);
      chk({read_ready, write_ready}, 2'b00);
      wait_lvl(access_enable, 1'b1);
      chk(refresh_enable, 1'b0);
      write_request_n <= 1'b1;
      refresh_request_clock <= 1'b1;
      wait_lvl(write_ready, 1'b1);
      chk({ras_n, cas_n}, 2'b11);
   endtask
   // Eighth write: pointer 0007, row byte then column byte with write strobe
   task automatic s_addr;
      write_request_n <= 1'b0;
      wait_lvl(access_enable, 1'b1);
      @(posedge sys_clk);
      chk(dram_addr, 8'h00);
      repeat (2) @(posedge sys_clk);
      chk({we_n, dram_addr}, 9'h007);
      write_request_n <= 1'b1;
      wait_lvl(write_ready, 1'b1);
   endtask
   initial begin
      #(25 * 5000);
      err_total++;
      end_sim();
   end
   initial begin
      repeat (4) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      chk({ras_n, cas_n, we_n, oe_n, read_ready, write_ready, empty, full}, 8'hFE);
      s_fifo();
      s_stall();
      s_priority();
      s_addr();
      internal_refresh_en <= 1'b1;
      for (int i = 0; i < 5; i++) acc(1'b1);
      chk(empty, 1'b1);
      internal_refresh_en <= 1'b0;
      end_sim();
   end
endmodule
bind dram_fifo_controller fifo_ctl_checker fifo_ctl_checker_i (.sys_clk(sys_clk),
   .arst_n(arst_n), .read_ready(read_ready), .write_ready(write_ready), .ras_n(ras_n),
   .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n), .access_enable(access_enable),
   .refresh_enable(refresh_enable), .full(full), .half_full(half_full), .empty(empty));
`default_nettype wire
